// ==== design/lser_status_regs.sv ====
// Link status and error registers with ack setup timing.
// Assumes port inputs are synchronous to clk; pins pass three flops.
`timescale 1ns/1ps
// Function
// - A read-only 16-bit back-channel CRC count shows at 0xA and 0xB.
// - The CRC count clears only on the external error-clear control.
// - Port-specific values follow the second-port select.
// - Bit 6 is the OR of five video-input errors, not cleared by read.
// - In dual modes bit 6 covers either video input.
// - Bit 5 is the OR of lane errors on the selected input, or on either input in dual modes, kept on read.
// - Bit 4 sets on link loss and holds until error clear.
// - Bit 3 sets on self-test CRC error, clears on restart or clear.
// - Bit 2 shows a valid pixel clock above the minimum frequency.
// - In split modes bit 2 shows the selected port.
// - Bit 1 sets on remote CRC error, clears on link loss or clear.
// - Bit 0 shows cable link detect on the selected port.
module lser_status_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire lser_pkg::lser_reg_req_type regReq,
  output logic [7:0] regRdata,
  input wire lser_pkg::lser_port_in_type port0In,
  input wire lser_pkg::lser_port_in_type port1In,
  input wire logic secondPortSelect,
  input wire logic dualInputMode,
  input wire logic errorClear,
  input wire logic selfTestRestart,
  input wire logic remoteAccessActive,
  input wire logic ackCycleStart,
  output logic ackDataRelease
);
  import lser_pkg::*;

  // ****************************************
  // Per-port sticky flags and counters
  // ****************************************
  logic [3:0] setupField_q, setupField_d;
  logic [15:0] crcCount_q [2];
  logic [15:0] crcCount_d [2];
  logic linkLost_q [2];
  logic linkLost_d [2];
  logic selfCrc_q [2];
  logic selfCrc_d [2];
  logic remCrc_q [2];
  logic remCrc_d [2];
  logic [7:0] highLatch_q, highLatch_d;
  logic [7:0] rdata_d;
  lser_port_in_type pin [2];
  lser_port_in_type sel;

  function automatic logic videoErr(input lser_port_in_type p);
    videoErr = p.bridgeForwardError | p.commandOverflow |
        p.endOfTransmissionError | p.readWithoutTurnaround |
        p.protocolErrorDetect;
  endfunction

  function automatic logic laneErr(input lser_port_in_type p);
    laneErr = p.laneSyncError | p.laneSignalFault;
  endfunction

  assign pin[0] = port0In;
  assign pin[1] = port1In;

  always_comb begin
    sel = secondPortSelect ? port1In : port0In;
    for (int i = 0; i < 2; i++) begin
      crcCount_d[i] = crcCount_q[i];
      if (errorClear) begin
        crcCount_d[i] = '0;
      end else if (pin[i].backChannelCrcError &&
          crcCount_q[i] != CRC_COUNT_MAX) begin
        crcCount_d[i] = crcCount_q[i] + CRC_COUNT_ONE;
      end
      // Set wins over clear so no event is lost
      linkLost_d[i] = pin[i].linkLoss |
          (linkLost_q[i] & ~errorClear);
      selfCrc_d[i] = pin[i].selfTestCrcError |
          (selfCrc_q[i] & ~errorClear & ~selfTestRestart);
      remCrc_d[i] = pin[i].remoteCrcError |
          (remCrc_q[i] & ~errorClear & ~pin[i].linkLoss);
    end
    setupField_d = setupField_q;
    if (regReq.write && regReq.addr == ADDR_ACK_SETUP) begin
      setupField_d = regReq.wdata[3:0];
    end
    highLatch_d = highLatch_q;
    rdata_d = 8'h00;
    if (regReq.read) begin
      case (regReq.addr)
        ADDR_ACK_SETUP: rdata_d = {4'h0, setupField_q};
        ADDR_CRC_LOW: begin
          rdata_d = crcCount_q[secondPortSelect][7:0];
          highLatch_d = crcCount_q[secondPortSelect][15:8];
        end
        ADDR_CRC_HIGH: rdata_d = highLatch_q;
        ADDR_STATUS: begin
          // Reads leave every flag untouched
          rdata_d[STS_VIDEO_ERR] = dualInputMode ?
              (videoErr(port0In) | videoErr(port1In)) :
              videoErr(sel);
          rdata_d[STS_LANE_ERR] = dualInputMode ?
              (laneErr(port0In) | laneErr(port1In)) :
              laneErr(sel);
          rdata_d[STS_LINK_LOST] = linkLost_q[secondPortSelect];
          rdata_d[STS_SELFTEST_CRC] = selfCrc_q[secondPortSelect];
          rdata_d[STS_PCLK] = sel.pixelClockValid;
          rdata_d[STS_REMOTE_CRC] = remCrc_q[secondPortSelect];
          rdata_d[STS_LINK_DETECT] = sel.cableLinkDetect;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setupField_q <= ACK_SETUP_RESET;
      highLatch_q <= 8'h00;
      regRdata <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        crcCount_q[i] <= '0;
        linkLost_q[i] <= 1'b0;
        selfCrc_q[i] <= 1'b0;
        remCrc_q[i] <= 1'b0;
      end
    end else begin
      setupField_q <= setupField_d;
      highLatch_q <= highLatch_d;
      regRdata <= rdata_d;
      for (int i = 0; i < 2; i++) begin
        crcCount_q[i] <= crcCount_d[i];
        linkLost_q[i] <= linkLost_d[i];
        selfCrc_q[i] <= selfCrc_d[i];
        remCrc_q[i] <= remCrc_d[i];
      end
    end
  end

  // ****************************************
  // Ack setup timer
  // ****************************************
  // Base rounds up to 4 cycles, step rounds down to 25; neither keeps the nominal figure
  logic [SETUP_CNT_W-1:0] setupCnt_q, setupCnt_d;
  logic busy_q, busy_d;
  logic release_d;

  always_comb begin
    setupCnt_d = setupCnt_q;
    busy_d = busy_q;
    release_d = 1'b0;
    if (ackCycleStart && remoteAccessActive) begin
      busy_d = 1'b1;
      setupCnt_d = SETUP_CNT_W'(SETUP_BASE_CYC) +
          SETUP_CNT_W'(SETUP_STEP_CYC) *
          SETUP_CNT_W'(setupField_q);
    end else if (busy_q) begin
      if (setupCnt_q <= SETUP_CNT_W'(1)) begin
        busy_d = 1'b0;
        release_d = 1'b1;
      end else begin
        setupCnt_d = setupCnt_q - SETUP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setupCnt_q <= '0;
      busy_q <= 1'b0;
      ackDataRelease <= 1'b0;
    end else begin
      setupCnt_q <= setupCnt_d;
      busy_q <= busy_d;
      ackDataRelease <= release_d;
    end
  end

  // ****************************************
  // Checks on port 0 flags, counter, timer and status port select
  // ****************************************
  chk_link_lost_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      linkLost_q[0] && !errorClear |=> linkLost_q[0])
    else $error("link lost flag dropped without clear");
  chk_link_lost_set: assert property (
      @(posedge clk) disable iff (!arst_n)
      port0In.linkLoss |=> linkLost_q[0])
    else $error("link lost flag missed an event");
  chk_crc_clear: assert property (
      @(posedge clk) disable iff (!arst_n)
      errorClear |=> crcCount_q[0] == '0)
    else $error("crc count not cleared");
  chk_crc_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      !port0In.backChannelCrcError && !errorClear
      |=> $stable(crcCount_q[0]))
    else $error("crc count moved without cause");
  chk_crc_saturate: assert property (
      @(posedge clk) disable iff (!arst_n)
      crcCount_q[0] == CRC_COUNT_MAX && !errorClear
      |=> crcCount_q[0] == CRC_COUNT_MAX)
    else $error("crc count wrapped");
  chk_crc_count: assert property (
      @(posedge clk) disable iff (!arst_n)
      port0In.backChannelCrcError && !errorClear &&
      crcCount_q[0] != CRC_COUNT_MAX
      |=> crcCount_q[0] == $past(crcCount_q[0]) + CRC_COUNT_ONE)
    else $error("crc count did not step");
  chk_self_clear: assert property (
      @(posedge clk) disable iff (!arst_n)
      selfTestRestart && !port0In.selfTestCrcError |=> !selfCrc_q[0])
    else $error("self-test flag survived restart");
  chk_self_set: assert property (
      @(posedge clk) disable iff (!arst_n)
      port0In.selfTestCrcError |=> selfCrc_q[0])
    else $error("self-test flag missed an event");
  chk_rem_clear: assert property (
      @(posedge clk) disable iff (!arst_n)
      port0In.linkLoss && !port0In.remoteCrcError |=> !remCrc_q[0])
    else $error("remote crc flag survived link loss");
  chk_rem_set: assert property (
      @(posedge clk) disable iff (!arst_n)
      port0In.remoteCrcError |=> remCrc_q[0])
    else $error("remote crc flag missed an event");
  // Release is registered, so it shows one edge after the count ends
  chk_setup_time: assert property (
      @(posedge clk) disable iff (!arst_n)
      ackCycleStart && remoteAccessActive && setupField_q == 4'h0
      ##1 !ackCycleStart [*4] |=> ackDataRelease)
    else $error("ack setup time wrong");
  chk_release_pulse: assert property (
      @(posedge clk) disable iff (!arst_n)
      ackDataRelease |=> !ackDataRelease)
    else $error("ack release longer than one cycle");
  chk_status_select: assert property (
      @(posedge clk) disable iff (!arst_n)
      regReq.read && regReq.addr == ADDR_STATUS
      |=> regRdata[STS_LINK_DETECT] == $past(sel.cableLinkDetect))
    else $error("link detect bit wrong port");
endmodule

// ==== design/lser_pkg.sv ====
// Package for the link status and error register slice.
// Assumes an 8-bit register port driven by the I2C slave logic.
package lser_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_ACK_SETUP = 8'h09;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h0A;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [3:0] ACK_SETUP_RESET = 4'h1;
  localparam logic [15:0] CRC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] CRC_COUNT_ONE = 16'h0001;
  localparam int STS_VIDEO_ERR = 6;
  localparam int STS_LANE_ERR = 5;
  localparam int STS_LINK_LOST = 4;
  localparam int STS_SELFTEST_CRC = 3;
  localparam int STS_PCLK = 2;
  localparam int STS_REMOTE_CRC = 1;
  localparam int STS_LINK_DETECT = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_BASE_NS = 80;
  localparam int SETUP_STEP_NS = 640;
  localparam int SETUP_BASE_CYC = (SETUP_BASE_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
  localparam int SETUP_STEP_CYC = SETUP_STEP_NS / CLK_PERIOD_NS;
  localparam int SETUP_CNT_W = 10;

  // Per-port raw event and level inputs
  typedef struct packed {
    logic bridgeForwardError;
    logic commandOverflow;
    logic endOfTransmissionError;
    logic readWithoutTurnaround;
    logic protocolErrorDetect;
    logic laneSyncError;
    logic laneSignalFault;
    logic linkLoss;
    logic selfTestCrcError;
    logic pixelClockValid;
    logic remoteCrcError;
    logic cableLinkDetect;
    logic backChannelCrcError;
  } lser_port_in_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lser_reg_req_type;
endpackage

// ==== verification/lser_host_model.sv ====
// Host model that issues one-cycle register accesses.
// Assumes the bench calls access only after reset release.
`timescale 1ns/1ps
module lser_host_model (
  input wire logic clk,
  output lser_pkg::lser_reg_req_type regReq,
  output logic dataValid
);
  import lser_pkg::*;
  initial regReq = '0;
  initial dataValid = 1'b0;
  // Read data is due one cycle after the strobe is taken
  always @(posedge clk) dataValid <= regReq.read;
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    regReq <= '{write: wr, read: !wr, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '0;
  endtask
endmodule

// ==== verification/lser_status_regs_test.sv ====
// Bench for the link status register slice.
// Assumes port inputs reach the flags within five cycles.
`timescale 1ns/1ps
module lser_status_regs_test;
  import lser_pkg::*;
  logic clk = 1'b0;
  logic arstN = 1'b0;
  lser_reg_req_type regReq;
  lser_port_in_type port0In = '0;
  lser_port_in_type port1In = '0;
  logic [7:0] regRdata;
  logic secondPortSelect = 1'b0;
  logic dualInputMode = 1'b0;
  logic errorClear = 1'b0;
  logic selfTestRestart = 1'b0;
  logic remoteAccessActive = 1'b0;
  logic ackCycleStart = 1'b0;
  logic ackDataRelease;
  logic dataValid;
  logic [7:0] expQ[$];
  logic [3:0] setups[3] = '{4'h0, 4'h1, 4'hF};
  int mismatches = 0;
  int checked = 0;
  int n, m, k;
  logic [7:0] e;
  always #12.5 clk = ~clk;
  lser_status_regs u_lser_status_regs (.clk(clk), .arst_n(arstN),
    .regReq(regReq), .regRdata(regRdata), .port0In(port0In),
    .port1In(port1In), .secondPortSelect(secondPortSelect),
    .dualInputMode(dualInputMode), .errorClear(errorClear),
    .selfTestRestart(selfTestRestart),
    .remoteAccessActive(remoteAccessActive),
    .ackCycleStart(ackCycleStart), .ackDataRelease(ackDataRelease));
  lser_host_model u_lser_host_model (.clk(clk), .regReq(regReq),
    .dataValid(dataValid));
  // ******************
  // Shared tasks
  // ******************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    expQ.push_back(x);
    u_lser_host_model.access(1'b0, a, 8'h00);
  endtask
  // Levels are held five cycles so the flags settle before any read
  task drive(input lser_port_in_type a, input lser_port_in_type b);
    @(posedge clk);
    port0In <= a;
    port1In <= b;
    idle(5);
  endtask
  task pulse(input lser_port_in_type a, input lser_port_in_type b);
    drive(a, b);
    drive('0, '0);
  endtask
  task clearErrors;
    @(posedge clk);
    errorClear <= 1'b1;
    @(posedge clk);
    errorClear <= 1'b0;
    idle(5);
  endtask
  // Oldest note is compared when read data is due
  always @(posedge clk)
    if (dataValid === 1'b1) check(16'(regRdata), 16'(expQ.pop_front()));
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    finish_test;
  end
  // ******************
  // Main sequence
  // ******************
  initial begin
    void'($urandom(32'h4E6D));
    repeat (6) @(posedge clk);
    arstN <= 1'b1;
    rd(ADDR_ACK_SETUP, 8'h01);
    rd(ADDR_CRC_HIGH, 8'h00);
    u_lser_host_model.access(1'b1, ADDR_CRC_LOW, 8'h5A);
    rd(ADDR_CRC_LOW, 8'h00);
    rd(8'h20, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    $display("reset value test done");
    remoteAccessActive <= 1'b1;
    foreach (setups[i]) begin
      u_lser_host_model.access(1'b1, ADDR_ACK_SETUP, {4'hA, setups[i]});
      rd(ADDR_ACK_SETUP, {4'h0, setups[i]});
      @(posedge clk);
      ackCycleStart <= 1'b1;
      @(posedge clk);
      ackCycleStart <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ackDataRelease !== 1'b1 && n < 500);
      check(16'(n),
            16'(SETUP_BASE_CYC + SETUP_STEP_CYC * setups[i] + 1));
    end
    // Without a remote access a start must never release the line
    remoteAccessActive <= 1'b0;
    @(posedge clk);
    ackCycleStart <= 1'b1;
    @(posedge clk);
    ackCycleStart <= 1'b0;
    n = 0;
    repeat (400) begin
      @(posedge clk);
      if (ackDataRelease !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    $display("setup timing test done");
    n = $urandom_range(20, 1);
    m = $urandom_range(20, 1);
    // One cycle per event, since the counter steps on every high cycle
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      port0In <= 13'(k < n);
      port1In <= 13'(k < m);
    end
    drive('0, '0);
    rd(ADDR_CRC_LOW, 8'(n));
    rd(ADDR_CRC_HIGH, 8'h00);
    rd(ADDR_CRC_LOW, 8'(n));
    secondPortSelect <= 1'b1;
    rd(ADDR_CRC_LOW, 8'(m));
    @(posedge clk);
    port1In <= 13'h0001;
    idle(65540);
    drive('0, '0);
    rd(ADDR_CRC_LOW, 8'hFF);
    rd(ADDR_CRC_HIGH, 8'hFF);
    clearErrors();
    rd(ADDR_CRC_LOW, 8'h00);
    secondPortSelect <= 1'b0;
    rd(ADDR_CRC_LOW, 8'h00);
    $display("crc counter test done");
    for (k = 6; k < 13; k++) begin
      e = (k > 7) ? 8'h40 : 8'h20;
      drive(13'(1) << k, '0);
      rd(ADDR_STATUS, e);
      rd(ADDR_STATUS, e);
      drive('0, 13'(1) << k);
      rd(ADDR_STATUS, 8'h00);
      dualInputMode <= 1'b1;
      idle(5);
      rd(ADDR_STATUS, e);
      dualInputMode <= 1'b0;
      drive('0, '0);
    end
    pulse(13'h0020, '0);
    rd(ADDR_STATUS, 8'h10);
    pulse(13'h0014, '0);
    rd(ADDR_STATUS, 8'h1A);
    selfTestRestart <= 1'b1;
    @(posedge clk);
    selfTestRestart <= 1'b0;
    pulse(13'h0020, '0);
    rd(ADDR_STATUS, 8'h10);
    pulse(13'h0014, '0);
    clearErrors();
    rd(ADDR_STATUS, 8'h00);
    drive(13'h000A, '0);
    rd(ADDR_STATUS, 8'h05);
    secondPortSelect <= 1'b1;
    drive('0, 13'h0008);
    rd(ADDR_STATUS, 8'h04);
    $display("status test done");
    idle(3);
    finish_test;
  end
endmodule
